// file: rtl/afe_pkg.sv
// Purpose: shared constants and types of the front-end register map
// Assumes: byte-wide registers on a 4-bit address
// Notes: sample registers occupy three addresses each, msb first

package afe_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int SAMPLE_W = 24;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [3:0] ADDR_CH0 = 4'h0;
	localparam logic [3:0] ADDR_CH0_LAST = 4'h2;
	localparam logic [3:0] ADDR_CH1 = 4'h3;
	localparam logic [3:0] ADDR_CH1_LAST = 4'h5;
	localparam logic [3:0] ADDR_RSVD = 4'h6;
	localparam logic [3:0] ADDR_SKEW = 4'h7;
	localparam logic [3:0] ADDR_AMP = 4'h8;
	localparam logic [3:0] ADDR_STATCOM = 4'h9;
	localparam logic [3:0] ADDR_CFG1 = 4'hA;
	localparam logic [3:0] ADDR_CFG2 = 4'hB;

	// ----------------------------------------------------------------
	// reset values and fields
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_SKEW = 8'h00;
	localparam logic [7:0] RST_AMP = 8'h00;
	localparam logic [7:0] RST_STATCOM = 8'h00;
	localparam logic [7:0] RST_CFG1 = 8'h00;
	localparam logic [7:0] RST_CFG2 = 8'h00;
	localparam logic [23:0] RST_SAMPLE = 24'h000000;
	localparam int STATCOM_READ_LSB = 6;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		RD_STATIC = 2'b00,
		RD_GROUP = 2'b01,
		RD_TYPE = 2'b10,
		RD_MAP = 2'b11
	} afe_rdmode_e;

	typedef enum logic {
		SEQ_IDLE = 1'b0,
		SEQ_BUSY = 1'b1
	} afe_seq_e;

	typedef struct packed {
		logic [23:0] ch1;
		logic [23:0] ch0;
	} afe_sample_s;

	typedef struct packed {
		logic [7:0] skew;
		logic [7:0] amp;
		logic [7:0] statcom;
		logic [7:0] cfg1;
		logic [7:0] cfg2;
	} afe_cfg_s;

endpackage

// file: rtl/afe_addr_step.sv
// Purpose: next address of a continuous read
// Assumes: current address lies inside the map
// Notes: purely combinational

`timescale 1ns/1ns

module afe_addr_step (
	input wire logic [3:0] cur_addr_i,
	input wire afe_pkg::afe_rdmode_e mode_i,
	output logic [3:0] next_addr_o
);

	logic [3:0] lo;
	logic [3:0] hi;

	// --------------------------------------------------------------
	// loop bounds of the selected set
	// --------------------------------------------------------------
	always_comb begin
		lo = cur_addr_i;
		hi = cur_addr_i;
		case (mode_i)
			afe_pkg::RD_GROUP: begin
				if (cur_addr_i <= afe_pkg::ADDR_CH0_LAST) begin
					lo = afe_pkg::ADDR_CH0;
					hi = afe_pkg::ADDR_CH0_LAST;
				end else if (cur_addr_i <= afe_pkg::ADDR_CH1_LAST) begin
					lo = afe_pkg::ADDR_CH1;
					hi = afe_pkg::ADDR_CH1_LAST;
				end else if (cur_addr_i <= afe_pkg::ADDR_AMP) begin
					lo = afe_pkg::ADDR_SKEW;
					hi = afe_pkg::ADDR_AMP;
				end else begin
					lo = afe_pkg::ADDR_STATCOM;
					hi = afe_pkg::ADDR_CFG2;
				end
			end
			afe_pkg::RD_TYPE: begin
				if (cur_addr_i <= afe_pkg::ADDR_CH1_LAST) begin
					lo = afe_pkg::ADDR_CH0;
					hi = afe_pkg::ADDR_CH1_LAST;
				end else begin
					lo = afe_pkg::ADDR_SKEW;
					hi = afe_pkg::ADDR_CFG2;
				end
			end
			afe_pkg::RD_MAP: begin
				lo = afe_pkg::ADDR_CH0;
				hi = afe_pkg::ADDR_CFG2;
			end
			default: begin
				lo = cur_addr_i;
				hi = cur_addr_i;
			end
		endcase
	end

	// --------------------------------------------------------------
	// step, wrap and reserved skip
	// --------------------------------------------------------------
	always_comb begin
		if (cur_addr_i >= hi) begin
			next_addr_o = lo;
		end else if (cur_addr_i + 4'h1 == afe_pkg::ADDR_RSVD) begin
			next_addr_o = afe_pkg::ADDR_SKEW;
		end else begin
			next_addr_o = cur_addr_i + 4'h1;
		end
	end

endmodule

// file: rtl/afe_sample_latch.sv
// Purpose: live and held copy of one channel result
// Assumes: load_i is a one-cycle pulse per conversion
// Notes: a hold in the same cycle as a load takes the newest word

`timescale 1ns/1ns

module afe_sample_latch #(
	parameter int W = 24
) (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic load_i,
	input wire logic [W-1:0] sample_i,
	input wire logic hold_i,
	output logic [W-1:0] live_o,
	output logic [W-1:0] held_o
);

	logic [W-1:0] live;
	logic [W-1:0] held;
	logic [W-1:0] next_live;
	logic [W-1:0] next_held;

	// --------------------------------------------------------------
	// all bytes replaced in one edge so no mixed word is seen
	// --------------------------------------------------------------
	always_comb begin
		next_live = load_i ? sample_i : live;
		next_held = held;
		if (hold_i) begin
			next_held = next_live;
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			live <= '0;
			held <= '0;
		end else begin
			live <= next_live;
			held <= next_held;
		end
	end

	assign live_o = live;
	assign held_o = held;

endmodule

// file: rtl/afe_regmap.sv
// Purpose: register map and continuous-read sequencing of the front end
// Assumes: all inputs synchronous to core_clk_i; strobes one cycle
// Notes: single reads see the newest sample, sequences a held copy
//
// The implementer's own choice: the plain strobed port.

`timescale 1ns/1ns

module afe_regmap #(
	parameter int ADDR_W = afe_pkg::ADDR_W,
	parameter int DATA_W = afe_pkg::DATA_W
) (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [DATA_W-1:0] rdata_o,
	input wire logic seq_start_i,
	input wire logic seq_rd_i,
	input wire logic seq_end_i,
	output logic seq_active_o,
	output logic [ADDR_W-1:0] seq_addr_o,
	input wire logic sample_valid_i,
	input wire afe_pkg::afe_sample_s sample_i,
	output afe_pkg::afe_cfg_s cfg_o,
	output logic [1:0] read_mode_o
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	afe_pkg::afe_cfg_s cfg;
	afe_pkg::afe_cfg_s next_cfg;
	afe_pkg::afe_seq_e seq_state;
	afe_pkg::afe_seq_e next_seq_state;
	afe_pkg::afe_rdmode_e mode;
	afe_pkg::afe_sample_s live;
	afe_pkg::afe_sample_s held;
	logic [ADDR_W-1:0] ptr;
	logic [ADDR_W-1:0] next_ptr;
	logic [ADDR_W-1:0] step_addr;
	logic [DATA_W-1:0] rdata;
	logic [DATA_W-1:0] next_rdata;
	logic hold;
	logic seq_take;

	// ----------------------------------------------------------------
	// byte selection shared by single and sequenced reads
	// ----------------------------------------------------------------
	// reserved and unmapped addresses answer zero; the host ignores it
	function automatic logic [7:0] reg_byte(
		input logic [3:0] a,
		input afe_pkg::afe_sample_s s,
		input afe_pkg::afe_cfg_s c
	);
		logic [7:0] b;
		b = 8'h00;
		case (a)
			afe_pkg::ADDR_CH0: b = s.ch0[23:16];
			4'h1: b = s.ch0[15:8];
			afe_pkg::ADDR_CH0_LAST: b = s.ch0[7:0];
			afe_pkg::ADDR_CH1: b = s.ch1[23:16];
			4'h4: b = s.ch1[15:8];
			afe_pkg::ADDR_CH1_LAST: b = s.ch1[7:0];
			afe_pkg::ADDR_SKEW: b = c.skew;
			afe_pkg::ADDR_AMP: b = c.amp;
			afe_pkg::ADDR_STATCOM: b = c.statcom;
			afe_pkg::ADDR_CFG1: b = c.cfg1;
			afe_pkg::ADDR_CFG2: b = c.cfg2;
			default: b = 8'h00;
		endcase
		return b;
	endfunction

	// ----------------------------------------------------------------
	// read mode field
	// ----------------------------------------------------------------
	// taken live, so a write that changes it steers the next step
	assign mode = afe_pkg::afe_rdmode_e'(
		cfg.statcom[afe_pkg::STATCOM_READ_LSB +: 2]);

	// ----------------------------------------------------------------
	// sample storage, one latch per channel
	// ----------------------------------------------------------------
	// a hold is taken whenever a read communication opens
	assign hold = seq_start_i;

	afe_sample_latch #(
		.W(afe_pkg::SAMPLE_W)
	) u_ch0 (
		.core_clk_i(core_clk_i),
		.nrst_i(nrst_i),
		.load_i(sample_valid_i),
		.sample_i(sample_i.ch0),
		.hold_i(hold),
		.live_o(live.ch0),
		.held_o(held.ch0)
	);

	afe_sample_latch #(
		.W(afe_pkg::SAMPLE_W)
	) u_ch1 (
		.core_clk_i(core_clk_i),
		.nrst_i(nrst_i),
		.load_i(sample_valid_i),
		.sample_i(sample_i.ch1),
		.hold_i(hold),
		.live_o(live.ch1),
		.held_o(held.ch1)
	);

	// ----------------------------------------------------------------
	// address sequencer
	// ----------------------------------------------------------------
	afe_addr_step u_step (
		.cur_addr_i(ptr),
		.mode_i(mode),
		.next_addr_o(step_addr)
	);

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	// writes below 0x07 fall on read-only or reserved space and are lost
	always_comb begin
		next_cfg = cfg;
		if (wr_i) begin
			case (addr_i)
				afe_pkg::ADDR_SKEW: next_cfg.skew = wdata_i;
				afe_pkg::ADDR_AMP: next_cfg.amp = wdata_i;
				afe_pkg::ADDR_STATCOM: next_cfg.statcom = wdata_i;
				afe_pkg::ADDR_CFG1: next_cfg.cfg1 = wdata_i;
				afe_pkg::ADDR_CFG2: next_cfg.cfg2 = wdata_i;
				default: next_cfg = cfg;
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cfg.skew <= afe_pkg::RST_SKEW;
			cfg.amp <= afe_pkg::RST_AMP;
			cfg.statcom <= afe_pkg::RST_STATCOM;
			cfg.cfg1 <= afe_pkg::RST_CFG1;
			cfg.cfg2 <= afe_pkg::RST_CFG2;
		end else begin
			cfg <= next_cfg;
		end
	end

	// ----------------------------------------------------------------
	// continuous read state
	// ----------------------------------------------------------------
	// a single read in the same cycle wins the data path, so the
	// sequenced byte is not taken and the pointer stays put
	assign seq_take = seq_rd_i && !rd_i && (seq_state == afe_pkg::SEQ_BUSY);

	always_comb begin
		next_seq_state = seq_state;
		next_ptr = ptr;
		case (seq_state)
			afe_pkg::SEQ_IDLE: begin
				if (seq_start_i) begin
					next_seq_state = afe_pkg::SEQ_BUSY;
					next_ptr = addr_i;
				end
			end
			afe_pkg::SEQ_BUSY: begin
				if (seq_start_i) begin
					next_ptr = addr_i; // restart takes a fresh hold
				end else if (seq_end_i) begin
					next_seq_state = afe_pkg::SEQ_IDLE;
				end else if (seq_take) begin
					next_ptr = step_addr;
				end
			end
			default: begin
				next_seq_state = afe_pkg::SEQ_IDLE;
				next_ptr = ptr;
			end
		endcase
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			seq_state <= afe_pkg::SEQ_IDLE;
			ptr <= '0;
		end else begin
			seq_state <= next_seq_state;
			ptr <= next_ptr;
		end
	end

	// ----------------------------------------------------------------
	// read data path
	// ----------------------------------------------------------------
	// sequenced bytes come from the held copy so a conversion landing
	// mid-read cannot tear a word; single reads see the newest one
	always_comb begin
		next_rdata = 8'h00;
		if (rd_i) begin
			next_rdata = reg_byte(addr_i, live, cfg);
		end else if (seq_take) begin
			next_rdata = reg_byte(ptr, held, cfg);
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata <= 8'h00;
		end else begin
			rdata <= next_rdata;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign rdata_o = rdata;
	assign seq_active_o = (seq_state == afe_pkg::SEQ_BUSY);
	assign seq_addr_o = ptr;
	assign cfg_o = cfg;
	assign read_mode_o = mode;

endmodule

// file: tb/afe_host_model.sv
// Purpose: host controller driving the register and sequence ports
// Assumes: one request at a time, changed just after a rising edge
// Notes: released address and data lines show the inverted last value
`timescale 1ns/1ns
module afe_host_model (
	input wire logic core_clk_i,
	input wire logic [7:0] rdata_i,
	output logic [3:0] addr_o,
	output logic [7:0] wdata_o,
	output logic wr_o,
	output logic rd_o,
	output logic seq_start_o,
	output logic seq_rd_o,
	output logic seq_end_o
);
	// idle bus at time zero
	initial begin
		{addr_o, wdata_o, wr_o, rd_o} = '0;
		{seq_start_o, seq_rd_o, seq_end_o} = '0;
	end
	// the reserved slot is never written, so such a call is dropped
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		if (a == 4'h6) return;
		@(posedge core_clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge core_clk_i);
		wr_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~d;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge core_clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge core_clk_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		#1 d = rdata_i;
	endtask
	// open a communication at a start address
	task automatic seq_open(input logic [3:0] a);
		@(posedge core_clk_i);
		addr_o <= a;
		seq_start_o <= 1'b1;
		@(posedge core_clk_i);
		seq_start_o <= 1'b0;
		addr_o <= ~a;
	endtask
	// one byte at the pointer
	task automatic seq_byte(output logic [7:0] d);
		@(posedge core_clk_i);
		seq_rd_o <= 1'b1;
		@(posedge core_clk_i);
		seq_rd_o <= 1'b0;
		#1 d = rdata_i;
	endtask
	task automatic seq_close();
		@(posedge core_clk_i);
		seq_end_o <= 1'b1;
		@(posedge core_clk_i);
		seq_end_o <= 1'b0;
	endtask
endmodule

// file: tb/afe_regmap_assertions.sv
// Purpose: port-level timing checks of the register map
// Assumes: one clock, asynchronous active-low reset
// Notes: step marks a byte read accepted inside a communication
`timescale 1ns/1ns
module afe_regmap_chk (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic seq_start_i,
	input wire logic seq_rd_i,
	input wire logic seq_end_i,
	input wire logic seq_active_o,
	input wire logic [3:0] seq_addr_o,
	input wire afe_pkg::afe_cfg_s cfg_o,
	input wire logic [1:0] read_mode_o
);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	logic step;
	// restart and close are excluded: restart reloads the pointer and close leaves it put
	assign step = seq_active_o && seq_rd_i && !rd_i && !seq_start_i
		&& !seq_end_i;
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);
	property p_idle; !rd_i && !seq_rd_i |=> rdata_o == 8'h00; endproperty
	property p_unmap; rd_i && addr_i >= 4'hC |=> rdata_o == 8'h00; endproperty
	property p_ro; wr_i && addr_i < 4'h7 |=> $stable(cfg_o); endproperty
	property p_wr; wr_i && addr_i == 4'h8 |=> cfg_o.amp == $past(wdata_i);
	endproperty
	property p_mode; read_mode_o == cfg_o.statcom[7:6]; endproperty
	property p_grp; step && read_mode_o == 2'b01 && seq_addr_o == 4'h2
		|=> seq_addr_o == 4'h0; endproperty
	property p_type; step && read_mode_o == 2'b10 && seq_addr_o == 4'hB
		|=> seq_addr_o == 4'h7; endproperty
	property p_map; step && read_mode_o == 2'b11 && seq_addr_o == 4'hB
		|=> seq_addr_o == 4'h0; endproperty
	property p_skip; step && read_mode_o == 2'b11 && seq_addr_o == 4'h5
		|=> seq_addr_o == 4'h7; endproperty
	property p_open; seq_start_i && addr_i != 4'h6
		|=> seq_active_o && seq_addr_o == $past(addr_i); endproperty
	a_idle: assert property (p_idle) else $error("rdata not idle");
	a_unmap: assert property (p_unmap) else $error("unmapped");
	a_ro: assert property (p_ro) else $error("ro write landed");
	a_wr: assert property (p_wr) else $error("cfg write lost");
	a_mode: assert property (p_mode) else $error("mode field");
	a_grp: assert property (p_grp) else $error("group wrap");
	a_type: assert property (p_type) else $error("type wrap");
	a_map: assert property (p_map) else $error("map wrap");
	a_skip: assert property (p_skip) else $error("no skip");
	a_open: assert property (p_open) else $error("open");
	// a close with no restart beside it must end the communication
	property p_close; seq_end_i && !seq_start_i && seq_active_o
		|=> !seq_active_o; endproperty
	a_close: assert property (p_close) else $error("close");
	c_grp: cover property (p_grp);
	c_close: cover property (p_close);
	c_map: cover property (p_map);
	c_open: cover property (p_open);
endmodule
bind afe_regmap afe_regmap_chk u_chk (.core_clk_i, .nrst_i, .addr_i,
	.wdata_i, .wr_i, .rd_i, .rdata_o, .seq_start_i, .seq_rd_i, .seq_end_i,
	.seq_active_o, .seq_addr_o, .cfg_o, .read_mode_o);

// file: tb/tb_top.sv
// Purpose: self-checking bench of the register map
// Assumes: host model owns the register and sequence ports
// Notes: expectations come from a shadow byte map kept here
`timescale 1ns/1ns
module tb_top;
	logic core_clk_i, nrst_i, wr_i, rd_i, sample_valid_i;
	logic seq_start_i, seq_rd_i, seq_end_i, seq_active_o;
	logic [3:0] addr_i, seq_addr_o;
	logic [7:0] wdata_i, rdata_o, d;
	logic [1:0] read_mode_o;
	afe_pkg::afe_sample_s sample_i;
	afe_pkg::afe_cfg_s cfg_o;
	logic [7:0] ref_m [16];
	int miscompares, samples_checked, i, k;
	afe_regmap u_dut (.core_clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i,
		.rd_i, .rdata_o, .seq_start_i, .seq_rd_i, .seq_end_i,
		.seq_active_o, .seq_addr_o, .sample_valid_i, .sample_i, .cfg_o,
		.read_mode_o);
	afe_host_model u_host (.core_clk_i, .rdata_i(rdata_o), .addr_o(addr_i),
		.wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i),
		.seq_start_o(seq_start_i), .seq_rd_o(seq_rd_i),
		.seq_end_o(seq_end_i));
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic test_done();
		$display("checked %0d, mismatched %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rd_chk(input logic [3:0] a);
		u_host.rd(a, d);
		chk("reg", ref_m[a], d);
	endtask
	// both channels refresh in one pulse, so all six bytes move together
	task automatic load(input logic [23:0] c0, input logic [23:0] c1);
		@(posedge core_clk_i);
		sample_valid_i <= 1'b1;
		sample_i <= {c1, c0};
		@(posedge core_clk_i);
		sample_valid_i <= 1'b0;
		{ref_m[0], ref_m[1], ref_m[2]} = c0;
		{ref_m[3], ref_m[4], ref_m[5]} = c1;
	endtask
	// pointer step worked out from the address sets of each mode
	function automatic logic [3:0] nxt(input logic [3:0] a, input logic [1:0] m);
		case (m)
			2'b00: nxt = a;
			2'b01: nxt = a == 4'h2 ? 4'h0 : a == 4'h5 ? 4'h3
				: a == 4'h8 ? 4'h7 : a == 4'hB ? 4'h9 : a + 4'h1;
			2'b10: nxt = a == 4'h5 ? 4'h0
				: a == 4'hB ? 4'h7 : a + 4'h1;
			default: nxt = a == 4'h5 ? 4'h7
				: a == 4'hB ? 4'h0 : a + 4'h1;
		endcase
	endfunction
	task automatic seq_chk(input logic [3:0] a, input int n, input logic [1:0] m);
		u_host.wr(4'h9, {m, 6'h15});
		ref_m[9] = {m, 6'h15};
		u_host.seq_open(a);
		// outputs move on the opening edge, so look just after it
		#1 chk("mode", {6'h00, m}, {6'h00, read_mode_o});
		chk("open", 8'h01, {7'h00, seq_active_o});
		repeat (n) begin
			chk("ptr", {4'h0, a}, {4'h0, seq_addr_o});
			u_host.seq_byte(d);
			chk("seq", ref_m[a], d);
			a = nxt(a, m);
		end
		u_host.seq_close();
		#1 chk("close", 8'h00, {7'h00, seq_active_o});
	endtask
	// ----------------------------------------------------------------
	// clock, watchdog and tests
	// ----------------------------------------------------------------
	initial begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end
	// the tests need well under a thousand cycles
	initial begin
		repeat (5000) @(posedge core_clk_i);
		miscompares++;
		test_done();
	end
	initial begin
		nrst_i = 1'b0;
		sample_valid_i = 1'b0;
		sample_i = '0;
		for (i = 0; i < 16; i++) ref_m[i] = 8'h00;
		repeat (20) @(posedge core_clk_i);
		nrst_i <= 1'b1;
		for (i = 7; i < 12; i++) rd_chk(i[3:0]);
		for (i = 7; i < 12; i++) begin
			u_host.wr(i[3:0], {i[3:0], 4'h5});
			ref_m[i] = {i[3:0], 4'h5};
		end
		for (i = 7; i < 12; i++) rd_chk(i[3:0]);
		u_host.wr(4'h0, 8'hFF);
		rd_chk(4'h0);
		rd_chk(4'hC);
		load(24'hA1B2C3, 24'hD4E5F6);
		for (i = 0; i < 6; i++) rd_chk(i[3:0]);
		seq_chk(4'h0, 4, 2'b01);
		seq_chk(4'h9, 4, 2'b01);
		seq_chk(4'h3, 4, 2'b10);
		seq_chk(4'hA, 3, 2'b10);
		seq_chk(4'h4, 3, 2'b11);
		seq_chk(4'hB, 2, 2'b11);
		seq_chk(4'h8, 2, 2'b00);
		u_host.wr(4'h9, 8'h55);
		ref_m[9] = 8'h55;
		u_host.seq_open(4'h3);
		u_host.seq_byte(d);
		chk("held", 8'hD4, d);
		load(24'h111111, 24'h222222);
		for (k = 0; k < 2; k++) begin
			u_host.seq_byte(d);
			chk("held", k == 0 ? 8'hE5 : 8'hF6, d);
		end
		u_host.seq_close();
		rd_chk(4'h4);
		// a reset in mid-communication closes it and clears the map
		u_host.seq_open(4'h0);
		nrst_i <= 1'b0;
		@(posedge core_clk_i);
		nrst_i <= 1'b1;
		#1 chk("reset", 8'h00, {7'h00, seq_active_o});
		for (i = 0; i < 12; i++) ref_m[i] = 8'h00;
		for (i = 0; i < 12; i++) begin
			if (i != 6) rd_chk(i[3:0]);
		end
		test_done();
	end
endmodule
